//--- design/serial_rx.sv
// Asynchronous serial receiver with two-character FIFO and AXI4-Lite
//
// Behaviour
// - Sample line at sixteen ticks per bit
// - Falling edge starts; recheck low at centre
// - High at start centre: drop silently
// - Majority-sample each bit one bit later
// - Stop sampled low sets framing error
// - Completed character moves into FIFO
// - FIFO holds two whole characters
// - Data read returns oldest, pops FIFO
// - Pending high while enabled and unread
// - Interrupt needs all three enables set
// - Framing error per entry, shows oldest
// - Framing error never stops or interrupts
// - Port disable clears framing; receive disable keeps
// - Third character while full sets overrun
// - Overrun cleared by disabling receive or the port
// - Nine-bit mode; ninth bit shows oldest
// - Address mode keeps ninth-bit-set characters only
// - Runs when enabled, async, port on
// - Data assembled least significant bit first
// - Port disable holds receiver, FIFO and overrun reset; control bits keep their values
// - Eight-bit mode ignores address detection
//
// Decided for this implementation: the AXI4-Lite interface to the registers and the register addresses.
`timescale 1ns/1ps

module serial_rx #(
  parameter int DATA_BITS = 9 // Widest character held in an entry
) (
  input  wire logic        aclk,          // System clock, 200 MHz
  input  wire logic        aresetn,       // Synchronous reset, active low
  input  wire logic        baud16_tick,   // Pulse at sixteen times baud
  input  wire logic        rx_pin,        // Receive line from the pin
  output logic             rx_pin_oe,     // Receive pin driver enable
  output logic             tx_pin_oe,     // Transmit pin driver enable
  output logic             rx_irq,        // Gated receive interrupt
  input  wire logic [7:0]  s_axi_awaddr,  // Write address
  input  wire logic        s_axi_awvalid, // Write address valid
  output logic             s_axi_awready, // Write address ready
  input  wire logic [31:0] s_axi_wdata,   // Write data
  input  wire logic [3:0]  s_axi_wstrb,   // Write byte enables
  input  wire logic        s_axi_wvalid,  // Write data valid
  output logic             s_axi_wready,  // Write data ready
  output logic [1:0]       s_axi_bresp,   // Write response
  output logic             s_axi_bvalid,  // Write response valid
  input  wire logic        s_axi_bready,  // Write response ready
  input  wire logic [7:0]  s_axi_araddr,  // Read address
  input  wire logic        s_axi_arvalid, // Read address valid
  output logic             s_axi_arready, // Read address ready
  output logic [31:0]      s_axi_rdata,   // Read data
  output logic [1:0]       s_axi_rresp,   // Read response
  output logic             s_axi_rvalid,  // Read data valid
  input  wire logic        s_axi_rready   // Read data ready
);

  // Only the documented nine-bit character fits the field layout
  if (DATA_BITS != 9)
  begin : g_width_check
    $error("serial_rx supports DATA_BITS of 9 only");
  end

  // ****************************************************************
  // Control state
  // ****************************************************************
  logic       serial_port_enable;    // Port on; off holds port reset
  logic       nine_bit_rx_select;    // Nine-bit characters
  logic       continuous_rx_enable;  // Receiver on
  logic       address_detect_enable; // Keep only address characters
  logic       sync_mode;             // Synchronous mode, not served
  logic       rx_irq_enable;         // Receive interrupt enable
  logic       peripheral_irq_enable; // Peripheral interrupt enable
  logic       global_irq_enable;     // Global interrupt enable
  logic       overrun_error;         // Sticky overrun
  logic       rx_enabled;            // Receiver may run
  logic       rx_pending_flag;       // Unread character present

  // Receiver runs only with all three settings right
  assign rx_enabled = continuous_rx_enable && !sync_mode &&
                      serial_port_enable;

  // Receive pin is always an input; port enable makes transmit an output
  assign rx_pin_oe = 1'b0;
  assign tx_pin_oe = serial_port_enable;

  // ****************************************************************
  // Pin synchroniser and filter
  // ****************************************************************
  logic [2:0] rx_sync;  // Three stages; stage 0 only feeds stage 1
  logic       rx_level; // Filtered line level
  logic       rx_prev;  // Level one cycle earlier, for edge finding

  // Line idles high; a change counts when stages 1 and 2 agree
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      rx_sync  <= 3'h7;
      rx_level <= 1'b1;
      rx_prev  <= 1'b1;
    end
    else
    begin
      rx_sync <= {rx_sync[1:0], rx_pin};
      if (rx_sync[1] == rx_sync[2])
      begin
        rx_level <= rx_sync[2];
      end
      rx_prev <= rx_level;
    end
  end

  // ****************************************************************
  // Data recovery
  // ****************************************************************
  serial_rx_pkg::rx_state_t state;       // Receiver state
  logic [3:0]               tick_cnt;    // Ticks into the current bit
  logic [1:0]               votes;       // Earlier two vote samples
  logic [3:0]               bit_idx;     // Next data bit position
  logic [8:0]               rx_shift_reg;// Character being assembled
  logic                     majority;    // Two of three samples
  logic                     decide;      // Decision tick of a bit
  logic                     last_bit;    // Last data bit of character
  logic                     stop_done;   // Stop bit just decided
  logic                     push;        // Character enters FIFO
  logic                     addr_drop;   // Filtered out in address mode
  logic                     rx_go;       // Receiver live and not overrun

  // Majority of the samples at ticks 7, 8 and 9
  assign majority = (votes[0] && votes[1]) || (votes[0] && rx_level) ||
                    (votes[1] && rx_level);
  assign decide   = baud16_tick && (tick_cnt == serial_rx_pkg::SAMPLE_LAST);
  assign last_bit = bit_idx == (nine_bit_rx_select ?
                    serial_rx_pkg::BITS_LONG : serial_rx_pkg::BITS_SHORT) -
                    4'h1;
  assign stop_done = decide && (state == serial_rx_pkg::RX_STOP);
  assign rx_go     = rx_enabled && !overrun_error;

  // Address mode only acts with nine-bit reception
  assign addr_drop = address_detect_enable && nine_bit_rx_select &&
                     !rx_shift_reg[8];

  // Tick counter and vote samples, at sixteen ticks per bit
  always_ff @(posedge aclk)
  begin
    if (!aresetn || state == serial_rx_pkg::RX_IDLE)
    begin
      tick_cnt <= 4'h0;
      votes    <= 2'h3;
    end
    else if (baud16_tick)
    begin
      // Wraps after tick 15 so each centre is one bit later
      tick_cnt <= (tick_cnt == serial_rx_pkg::TICKS_PER_BIT) ? 4'h0 :
                  tick_cnt + 4'h1;
      if (tick_cnt >= serial_rx_pkg::SAMPLE_FIRST &&
          tick_cnt <  serial_rx_pkg::SAMPLE_LAST)
      begin
        votes <= {votes[0], rx_level};
      end
    end
  end

  // Receiver sequence from start edge to stop bit
  always_ff @(posedge aclk)
  begin
    if (!aresetn || !rx_go)
    begin
      // Disabled or overrun: no further characters taken
      state   <= serial_rx_pkg::RX_IDLE;
      bit_idx <= 4'h0;
    end
    else
    begin
      unique case (state)
        serial_rx_pkg::RX_IDLE:
        begin
          // Falling edge of the line begins a character
          if (rx_prev && !rx_level)
          begin
            state   <= serial_rx_pkg::RX_START;
            bit_idx <= 4'h0;
          end
        end
        serial_rx_pkg::RX_START:
        begin
          if (decide)
          begin
            // Low at centre continues, high aborts silently
            state <= majority ? serial_rx_pkg::RX_IDLE :
                     serial_rx_pkg::RX_DATA;
          end
        end
        serial_rx_pkg::RX_DATA:
        begin
          if (decide)
          begin
            bit_idx <= bit_idx + 4'h1;
            if (last_bit)
            begin
              state <= serial_rx_pkg::RX_STOP;
            end
          end
        end
        serial_rx_pkg::RX_STOP:
        begin
          // A framing error still returns to hunting
          if (decide)
          begin
            state <= serial_rx_pkg::RX_IDLE;
          end
        end
      endcase
    end
  end

  // Shift register filled least significant bit first
  always_ff @(posedge aclk)
  begin
    if (!aresetn || !serial_port_enable)
    begin
      rx_shift_reg <= 9'h000;
    end
    else if (state == serial_rx_pkg::RX_START && decide)
    begin
      // Clear so an eight-bit character carries a zero ninth bit
      rx_shift_reg <= 9'h000;
    end
    else if (state == serial_rx_pkg::RX_DATA && decide)
    begin
      rx_shift_reg[bit_idx] <= majority;
    end
  end

  // ****************************************************************
  // Receive FIFO of two entries
  // ****************************************************************
  logic [9:0] fifo_mem [2]; // {framing error, nine data bits}
  logic       wr_ptr;       // Next slot to fill
  logic       rd_ptr;       // Oldest slot
  logic [1:0] fifo_count;   // Characters held, 0 to 2
  logic       pop;          // Data register read of a held character
  logic       full;         // Both slots taken
  logic [9:0] head;         // Oldest entry

  assign full = fifo_count == 2'h2;
  assign head = fifo_mem[rd_ptr];
  // Complete character enters unless filtered or full
  assign push = stop_done && rx_go && !addr_drop && !full;

  // Slot storage; a low stop level sets the entry's error bit
  always_ff @(posedge aclk)
  begin
    if (push)
    begin
      fifo_mem[wr_ptr] <= {!majority, rx_shift_reg};
    end
  end

  // Pointers and count; port disable empties the FIFO
  always_ff @(posedge aclk)
  begin
    if (!aresetn || !serial_port_enable)
    begin
      wr_ptr     <= 1'b0;
      rd_ptr     <= 1'b0;
      fifo_count <= 2'h0;
    end
    else
    begin
      if (push)
      begin
        wr_ptr <= !wr_ptr;
      end
      if (pop)
      begin
        rd_ptr <= !rd_ptr; // Next entry's status now shows
      end
      fifo_count <= fifo_count + {1'b0, push} - {1'b0, pop};
    end
  end

  // Overrun: set on a whole third character, cleared by disable
  always_ff @(posedge aclk)
  begin
    if (!aresetn || !serial_port_enable || !continuous_rx_enable)
    begin
      overrun_error <= 1'b0;
    end
    else if (stop_done && rx_go && !addr_drop && full)
    begin
      overrun_error <= 1'b1;
    end
  end

  // Pending follows enable and FIFO contents, not software
  assign rx_pending_flag = rx_enabled && (fifo_count != 2'h0);

  // Interrupt gated by all three enables; framing alone never
  assign rx_irq = rx_pending_flag && rx_irq_enable &&
                  peripheral_irq_enable && global_irq_enable;

  // ****************************************************************
  // AXI4-Lite slave
  // ****************************************************************
  logic        aw_held;  // Write address taken, waiting for data
  logic        w_held;   // Write data taken, waiting for address
  logic [7:0]  aw_addr;  // Held write address
  logic [31:0] w_data;   // Held write data
  logic        w_low;    // Held strobe of the low byte
  logic        do_write; // Both halves present, perform write
  logic [31:0] rd_word;  // Read mux output
  logic        rd_hit;   // Read address is mapped

  assign s_axi_awready = !aw_held && !s_axi_bvalid;
  assign s_axi_wready  = !w_held && !s_axi_bvalid;
  assign s_axi_arready = !s_axi_rvalid;
  assign do_write      = aw_held && w_held && !s_axi_bvalid;
  assign pop = s_axi_arvalid && s_axi_arready &&
               s_axi_araddr == serial_rx_pkg::RX_DATA_REG_OFS &&
               fifo_count != 2'h0;

  // Address and data taken in either order, response after both
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      aw_held      <= 1'b0;
      w_held       <= 1'b0;
      aw_addr      <= 8'h00;
      w_data       <= 32'h0000_0000;
      w_low        <= 1'b0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp  <= serial_rx_pkg::RESP_OKAY;
    end
    else
    begin
      if (s_axi_awvalid && s_axi_awready)
      begin
        aw_held <= 1'b1;
        aw_addr <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready)
      begin
        w_held <= 1'b1;
        w_data <= s_axi_wdata;
        w_low  <= s_axi_wstrb[0];
      end
      if (do_write)
      begin
        aw_held      <= 1'b0;
        w_held       <= 1'b0;
        s_axi_bvalid <= 1'b1;
        // Data register is read only here, so writes are ignored
        s_axi_bresp  <= (aw_addr == serial_rx_pkg::RX_STATUS_CONTROL_OFS ||
                         aw_addr == serial_rx_pkg::TX_STATUS_CONTROL_OFS ||
                         aw_addr == serial_rx_pkg::RX_DATA_REG_OFS ||
                         aw_addr == serial_rx_pkg::IRQ_CONTROL_OFS) ?
                        serial_rx_pkg::RESP_OKAY : serial_rx_pkg::RESP_DECERR;
      end
      else if (s_axi_bvalid && s_axi_bready)
      begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  // Writable control bits; status bits ignore writes
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      serial_port_enable    <= serial_rx_pkg::CTRL_RESET;
      nine_bit_rx_select    <= serial_rx_pkg::CTRL_RESET;
      continuous_rx_enable  <= serial_rx_pkg::CTRL_RESET;
      address_detect_enable <= serial_rx_pkg::CTRL_RESET;
      sync_mode             <= serial_rx_pkg::CTRL_RESET;
      rx_irq_enable         <= serial_rx_pkg::CTRL_RESET;
      peripheral_irq_enable <= serial_rx_pkg::CTRL_RESET;
      global_irq_enable     <= serial_rx_pkg::CTRL_RESET;
    end
    else if (do_write && w_low)
    begin
      if (aw_addr == serial_rx_pkg::RX_STATUS_CONTROL_OFS)
      begin
        serial_port_enable    <= w_data[serial_rx_pkg::PORT_BIT];
        nine_bit_rx_select    <= w_data[serial_rx_pkg::NINE_BIT];
        continuous_rx_enable  <= w_data[serial_rx_pkg::RXEN_BIT];
        address_detect_enable <= w_data[serial_rx_pkg::ADDR_BIT];
      end
      if (aw_addr == serial_rx_pkg::TX_STATUS_CONTROL_OFS)
      begin
        sync_mode <= w_data[serial_rx_pkg::SYNC_BIT];
      end
      if (aw_addr == serial_rx_pkg::IRQ_CONTROL_OFS)
      begin
        rx_irq_enable         <= w_data[serial_rx_pkg::RXIE_BIT];
        peripheral_irq_enable <= w_data[serial_rx_pkg::PERIPH_BIT];
        global_irq_enable     <= w_data[serial_rx_pkg::GLOBAL_BIT];
      end
    end
  end

  // Read mux; framing and ninth-bit status show the oldest entry only
  always_comb
  begin
    rd_word = 32'h0000_0000;
    rd_hit  = 1'b1;
    unique case (s_axi_araddr)
      serial_rx_pkg::RX_STATUS_CONTROL_OFS:
      begin
        rd_word[serial_rx_pkg::PORT_BIT]  = serial_port_enable;
        rd_word[serial_rx_pkg::NINE_BIT]  = nine_bit_rx_select;
        rd_word[serial_rx_pkg::RXEN_BIT]  = continuous_rx_enable;
        rd_word[serial_rx_pkg::ADDR_BIT]  = address_detect_enable;
        rd_word[serial_rx_pkg::FRAME_BIT] = (fifo_count != 2'h0) && head[9];
        rd_word[serial_rx_pkg::OVER_BIT]  = overrun_error;
        rd_word[serial_rx_pkg::NINTH_BIT] = (fifo_count != 2'h0) && head[8];
      end
      serial_rx_pkg::TX_STATUS_CONTROL_OFS:
      begin
        rd_word[serial_rx_pkg::SYNC_BIT] = sync_mode;
      end
      serial_rx_pkg::RX_DATA_REG_OFS:
      begin
        // Oldest character's low eight bits; empty reads zero
        rd_word[7:0] = (fifo_count != 2'h0) ? head[7:0] : 8'h00;
      end
      serial_rx_pkg::IRQ_CONTROL_OFS:
      begin
        rd_word[serial_rx_pkg::RXIE_BIT]   = rx_irq_enable;
        rd_word[serial_rx_pkg::PERIPH_BIT] = peripheral_irq_enable;
        rd_word[serial_rx_pkg::GLOBAL_BIT] = global_irq_enable;
        rd_word[serial_rx_pkg::PEND_BIT]   = rx_pending_flag;
      end
      default:
      begin
        rd_hit = 1'b0;
      end
    endcase
  end

  // Read answer registered one cycle after the address is taken
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata  <= 32'h0000_0000;
      s_axi_rresp  <= serial_rx_pkg::RESP_OKAY;
    end
    else if (s_axi_arvalid && s_axi_arready)
    begin
      s_axi_rvalid <= 1'b1;
      s_axi_rdata  <= rd_word;
      s_axi_rresp  <= rd_hit ? serial_rx_pkg::RESP_OKAY :
                      serial_rx_pkg::RESP_DECERR;
    end
    else if (s_axi_rvalid && s_axi_rready)
    begin
      s_axi_rvalid <= 1'b0;
    end
  end

  // ****************************************************************
  // Checks
  // ****************************************************************
  // One clock and one reset serve every check below
  default clocking check_clk @(posedge aclk);
  endclocking
  default disable iff (!aresetn);

  start_abort_a: assert property (
    state == serial_rx_pkg::RX_START && decide && majority && rx_go
    |=> state == serial_rx_pkg::RX_IDLE &&
        overrun_error == $past(overrun_error))
    else $error("start abort did not return to idle");

  overrun_set_a: assert property (
    stop_done && rx_go && !addr_drop && full && continuous_rx_enable &&
    !pop
    |=> overrun_error && fifo_count == 2'h2)
    else $error("overrun not set on third character");

  overrun_block_a: assert property (
    overrun_error && continuous_rx_enable |-> !push)
    else $error("character accepted during overrun");

  port_reset_a: assert property (
    !serial_port_enable |=> fifo_count == 2'h0 && !overrun_error)
    else $error("port disable did not reset receiver");

  irq_gate_a: assert property (
    rx_irq |-> rx_irq_enable && peripheral_irq_enable &&
               global_irq_enable && fifo_count != 2'h0)
    else $error("interrupt without all enables");

  addr_filter_a: assert property (
    push && address_detect_enable && nine_bit_rx_select |-> rx_shift_reg[8])
    else $error("non-address character entered FIFO");

  pop_count_a: assert property (
    pop && !push && serial_port_enable ##1 serial_port_enable
    |-> fifo_count == $past(fifo_count) - 2'h1)
    else $error("data read did not pop FIFO");

  fifo_bound_a: assert property (
    fifo_count <= 2'h2)
    else $error("FIFO count beyond two");

  pending_rise_a: assert property (
    push && rx_enabled ##1 rx_enabled |-> rx_pending_flag)
    else $error("pending not raised after push");

endmodule // serial_rx

//--- pkg/serial_rx_pkg.sv
// Constants shared by the asynchronous serial receiver
package serial_rx_pkg;

  // ****************************************************************
  // Register byte offsets on the AXI4-Lite bus
  // ****************************************************************
  localparam logic [7:0] RX_STATUS_CONTROL_OFS = 8'h00; // Control, status
  localparam logic [7:0] TX_STATUS_CONTROL_OFS = 8'h04; // Mode select
  localparam logic [7:0] RX_DATA_REG_OFS       = 8'h08; // Popping data read
  localparam logic [7:0] IRQ_CONTROL_OFS       = 8'h0C; // Enables, pending

  // ****************************************************************
  // Field positions
  // ****************************************************************
  localparam int PORT_BIT    = 7; // Serial port enable
  localparam int NINE_BIT    = 6; // Nine-bit reception select
  localparam int RXEN_BIT    = 4; // Continuous receive enable
  localparam int ADDR_BIT    = 3; // Address detect enable
  localparam int FRAME_BIT   = 2; // Framing error, read only
  localparam int OVER_BIT    = 1; // Overrun error, read only
  localparam int NINTH_BIT   = 0; // Ninth data bit, read only
  localparam int SYNC_BIT    = 4; // Mode select in the transmit register
  localparam int RXIE_BIT    = 0; // Receive interrupt enable
  localparam int PERIPH_BIT  = 1; // Peripheral interrupt enable
  localparam int GLOBAL_BIT  = 2; // Global interrupt enable
  localparam int PEND_BIT    = 8; // Receive pending flag, read only

  // ****************************************************************
  // Reset values and timing
  // ****************************************************************
  localparam logic       CTRL_RESET      = 1'b0;  // All enables off
  localparam logic [3:0] TICKS_PER_BIT   = 4'hF;  // Last tick of a bit
  localparam logic [3:0] SAMPLE_FIRST    = 4'h7;  // First vote sample
  localparam logic [3:0] SAMPLE_LAST     = 4'h9;  // Last vote, decision
  localparam logic [3:0] BITS_SHORT      = 4'h8;  // Eight-bit characters
  localparam logic [3:0] BITS_LONG       = 4'h9;  // Nine-bit characters
  localparam logic [1:0] RESP_OKAY       = 2'h0;  // AXI okay
  localparam logic [1:0] RESP_DECERR     = 2'h3;  // AXI unmapped address

  // Receiver states
  typedef enum logic [1:0] {
    RX_IDLE  = 2'b00,
    RX_START = 2'b01,
    RX_DATA  = 2'b10,
    RX_STOP  = 2'b11
  } rx_state_t;

endpackage

//--- verification/serial_tx_model.sv
// Remote asynchronous transmitter model that also makes the baud tick
`timescale 1ns/1ps
module serial_tx_model (
  input  wire logic aclk,        // System clock
  output logic      baud16_tick, // One pulse every fourth clock
  output logic      rx_pin       // Serial line, idle high
);
  logic [1:0] div; // Tick divider
  initial {div, baud16_tick, rx_pin} = 4'h1;
  // Tick runs free, as a real baud generator does between frames
  always @(posedge aclk)
  begin
    div         <= div + 2'h1;
    baud16_tick <= (div == 2'h3);
  end
  // Start bit, data least significant first, stop; sixteen ticks each
  task automatic send(input logic [8:0] d, input int n, input logic stp);
    for (int i = 0; i < n + 2; i++)
    begin
      rx_pin <= (i == 0) ? 1'b0 : (i > n) ? stp : d[i-1];
      repeat (16) @(posedge aclk iff baud16_tick);
    end
    rx_pin <= 1'b1;
    repeat (16) @(posedge aclk iff baud16_tick);
  endtask
  // Low pulse that is high again before the start centre is reached;
  // waits past a whole frame so a receiver that failed to abort pushes
  task automatic glitch();
    rx_pin <= 1'b0;
    repeat (4) @(posedge aclk iff baud16_tick);
    rx_pin <= 1'b1;
    repeat (160) @(posedge aclk iff baud16_tick);
  endtask
endmodule // serial_tx_model

//--- verification/test_async_serial_receiver.sv
// Self-checking testbench for the asynchronous serial receiver
`timescale 1ns/1ps
module test_async_serial_receiver;
  logic        aclk, aresetn, baud16_tick, rx_pin, rx_pin_oe, tx_pin_oe;
  logic        rx_irq, s_axi_awvalid, s_axi_awready, s_axi_wvalid;
  logic        s_axi_wready, s_axi_bvalid, s_axi_bready, s_axi_arvalid;
  logic        s_axi_arready, s_axi_rvalid, s_axi_rready;
  logic [7:0]  s_axi_awaddr, s_axi_araddr;
  logic [31:0] s_axi_wdata, s_axi_rdata;
  logic [3:0]  s_axi_wstrb;
  logic [1:0]  s_axi_bresp, s_axi_rresp;
  int          n_mismatch = 0, compares = 0;
  serial_rx i_serial_rx (.aclk, .aresetn, .baud16_tick, .rx_pin, .rx_pin_oe,
    .tx_pin_oe, .rx_irq, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
    .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
    .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid,
    .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready);
  serial_tx_model i_serial_tx_model (.aclk, .baud16_tick, .rx_pin);
  // Count and report one comparison
  task automatic eq(input logic [31:0] g, input logic [31:0] e);
    compares++;
    if (g !== e)
    begin
      n_mismatch++;
      $display("[FAIL] %0t got %h expected %h", $time, g, e);
    end
  endtask
  // Write: address and data offered together, each released when taken;
  // ready stays high after, so a back-to-back call never drives it twice
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    s_axi_awaddr  <= a;
    s_axi_wdata   <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid  <= 1'b1;
    s_axi_bready  <= 1'b1;
    do
    begin
      @(posedge aclk);
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
    end while (s_axi_bvalid !== 1'b1);
  endtask
  // Read and compare; offsets past the last register expect a decode error
  task automatic ck(input logic [7:0] a, input logic [31:0] e);
    s_axi_araddr  <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready  <= 1'b1;
    do
    begin
      @(posedge aclk);
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
    end while (s_axi_rvalid !== 1'b1);
    eq(s_axi_rdata, e);
    eq({30'h0, s_axi_rresp}, {30'h0, (a > 8'h0C) ?
      serial_rx_pkg::RESP_DECERR : serial_rx_pkg::RESP_OKAY});
  endtask
  // Counts, verdict and end of run
  task automatic results();
    $display("compares %0d mismatches %0d", compares, n_mismatch);
    if (n_mismatch == 0 && compares > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask
  initial
  begin
    aclk = 1'b0;
    forever #2.5 aclk = ~aclk;
  end
  // Watchdog: the tests need about 7300 cycles
  initial
  begin
    repeat (40000) @(posedge aclk);
    n_mismatch++;
    results();
  end
  initial
  begin
    {aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready} = 4'h0;
    {s_axi_arvalid, s_axi_rready, s_axi_awaddr, s_axi_araddr} = 18'h0;
    {s_axi_wdata, s_axi_wstrb} = 36'h00000000F;
    repeat (6) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    ck(8'h00, 32'h0);
    ck(8'h10, 32'h0);
    wr(8'h00, 32'h90);
    wr(8'h0C, 32'h107);
    ck(8'h0C, 32'h7);
    eq({31'h0, tx_pin_oe}, 32'h1);
    eq({31'h0, rx_pin_oe}, 32'h0);
    i_serial_tx_model.send(9'h0A5, 8, 1'b1);
    eq({31'h0, rx_irq}, 32'h1);
    wr(8'h0C, 32'h3);
    eq({31'h0, rx_irq}, 32'h0);
    ck(8'h0C, 32'h103);
    ck(8'h08, 32'hA5);
    i_serial_tx_model.glitch();
    ck(8'h0C, 32'h3);
    ck(8'h00, 32'h90);
    $display("test basic done");
    i_serial_tx_model.send(9'h011, 8, 1'b1);
    i_serial_tx_model.send(9'h022, 8, 1'b0);
    i_serial_tx_model.send(9'h033, 8, 1'b1);
    ck(8'h00, 32'h92);
    ck(8'h08, 32'h11);
    ck(8'h00, 32'h96);
    wr(8'h00, 32'h80);
    ck(8'h00, 32'h84);
    wr(8'h00, 32'h00);
    ck(8'h00, 32'h00);
    wr(8'h00, 32'h90);
    ck(8'h08, 32'h00);
    wr(8'h04, 32'h10);
    i_serial_tx_model.send(9'h077, 8, 1'b1);
    ck(8'h08, 32'h00);
    wr(8'h04, 32'h00);
    $display("test errors done");
    wr(8'h00, 32'h98);
    i_serial_tx_model.send(9'h055, 8, 1'b1);
    ck(8'h08, 32'h55);
    wr(8'h00, 32'hD8);
    i_serial_tx_model.send(9'h055, 9, 1'b1);
    i_serial_tx_model.send(9'h1AA, 9, 1'b1);
    ck(8'h00, 32'hD9);
    ck(8'h08, 32'hAA);
    wr(8'h00, 32'hD0);
    i_serial_tx_model.send(9'h0C3, 9, 1'b1);
    ck(8'h00, 32'hD0);
    ck(8'h08, 32'hC3);
    ck(8'h0C, 32'h3);
    $display("test nine done");
    results();
  end
endmodule // test_async_serial_receiver
